// *** tmc_pkg.sv ***
// Purpose: Shared constants and types for the timer modulo and channel block
// Assumes: AXI4-Lite register access, 32-bit data, byte registers in low bits
// Notes:   Register indexes times four give the byte addresses
`default_nettype none
package tmc_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_LIMIT_HI = 8'h13;  // counter_limit_high
  localparam logic [7:0] IDX_LIMIT_LO = 8'h14;  // counter_limit_low
  localparam logic [7:0] IDX_CH0_SC   = 8'h15;  // channel0_status_control
  localparam logic [7:0] IDX_CH1_SC   = 8'h18;  // channel1_status_control
  localparam int         ADDR_W       = 8;      // AXI address width
  localparam int         DATA_W       = 32;     // AXI data width
  localparam int         NUM_CH       = 2;      // Channel count
  // Field positions in a channel status/control byte
  localparam int BIT_FLAG   = 7;                // chan_event_flag
  localparam int BIT_IRQ_EN = 6;                // chan_irq_enable
  localparam int BIT_MODE_H = 5;                // chan_mode_hi
  localparam int BIT_MODE_L = 4;                // chan_mode_lo
  localparam int BIT_EL_H   = 3;                // chan_edge_level_hi
  localparam int BIT_EL_L   = 2;                // chan_edge_level_lo
  // Reset values
  localparam logic [15:0] LIMIT_RST = 16'h0000; // Modulo disabled
  localparam logic [7:0]  SC_RST    = 8'h00;    // Channel byte reset
  localparam logic [15:0] FULL_TOP  = 16'hFFFF; // Free-running terminal count
  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;    // Mapped access
  localparam logic [1:0] RESP_SLVERR = 2'h2;    // Unmapped access
  // Counter direction
  typedef enum logic {TMC_UP, TMC_DOWN} tmc_dir_t;
  // Channel control fields as stored
  typedef struct packed {
    logic       irq_en;    // chan_irq_enable
    logic [1:0] mode;      // chan_mode_hi, chan_mode_lo
    logic [1:0] edge_lvl;  // chan_edge_level_hi, chan_edge_level_lo
  } tmc_chan_ctrl_t;
  // Bus events delivered to one channel
  typedef struct packed {
    logic       rd;        // Status byte read accepted
    logic       wr;        // Status byte write
    logic [7:0] wdata;     // Written byte
  } tmc_chan_bus_t;
endpackage : tmc_pkg
`default_nettype wire

// *** tmc_chan.sv ***
// Purpose: One timer channel: event flag, clear sequence, pin action
// Assumes: tick is a one-cycle enable on clk; pin_in already synchronised
// Notes:   Flag set wins over a clear arriving in the same cycle
`default_nettype none
module tmc_chan (
  input  wire logic               clk,       // System clock
  input  wire logic               rst_n,     // Async reset, active low
  input  wire logic               tick,      // Timer clock enable
  input  wire logic               center,    // center_align_select
  input  wire logic [15:0]        count,     // Counter value
  input  wire logic [15:0]        value,     // Channel value
  input  wire logic               pin_in,    // Synchronised pin level
  input  wire tmc_pkg::tmc_chan_bus_t  bus,  // Register access events
  output logic [7:0]              sc_byte,   // Status/control readback
  output logic                    irq,       // Interrupt request
  output logic                    pin_out,   // Pin drive level
  output logic                    pin_oe     // Pin driven by timer
);
  tmc_pkg::tmc_chan_ctrl_t ctrl;             // Stored control bits
  logic                    flag;             // chan_event_flag
  logic                    armed;            // Clear sequence armed
  logic                    pin_prev;         // Last pin level
  logic                    event_hit;        // Capture or compare event
  logic                    cap_mode;         // Input capture selected
  logic                    match;            // Counter equals value
  logic                    rise;             // Rising pin edge
  logic                    fall;             // Falling pin edge

  assign cap_mode = !center && ctrl.mode == 2'b00;
  assign match    = tick && count == value;
  assign rise     = pin_in && !pin_prev;
  assign fall     = !pin_in && pin_prev;

  // Event source per mode
  always_comb begin
    if (cap_mode) begin
      event_hit = (ctrl.edge_lvl[0] && rise) || (ctrl.edge_lvl[1] && fall);
    end else begin
      event_hit = match;
    end
  end

  // Pin history for edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= pin_in;
    end
  end

  // Control bits; writes to the flag position are handled below
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= '0;
    end else if (bus.wr) begin
      ctrl <= bus.wdata[tmc_pkg::BIT_IRQ_EN:tmc_pkg::BIT_EL_L];
    end
  end

  // Arm on a read that sees the flag set; a new event disarms
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed <= 1'b0;
    end else if (event_hit) begin
      armed <= 1'b0;
    end else if (bus.rd && flag) begin
      armed <= 1'b1;
    end else if (bus.wr) begin
      armed <= 1'b0;
    end
  end

  // Event flag: set has priority over the clearing write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (event_hit) begin
      flag <= 1'b1;
    end else if (bus.wr && armed && !bus.wdata[tmc_pkg::BIT_FLAG]) begin
      flag <= 1'b0;
    end
  end

  // Pin action on compare and PWM; held level otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= 1'b0;
    end else if (tick && (center || ctrl.mode[1])) begin
      // Clear-on-match polarity is high before the match point
      pin_out <= ctrl.edge_lvl[0] ^ (count < value);
    end else if (match && ctrl.mode == 2'b01 && !center) begin
      case (ctrl.edge_lvl)
        2'b01:   pin_out <= !pin_out;   // Toggle
        2'b10:   pin_out <= 1'b0;       // Clear
        2'b11:   pin_out <= 1'b1;       // Set
        default: pin_out <= pin_out;    // Software compare only
      endcase
    end
  end

  assign pin_oe  = ctrl.edge_lvl != 2'b00 && !cap_mode;
  assign irq     = flag && ctrl.irq_en;
  assign sc_byte = {flag, ctrl, 2'b00};
endmodule : tmc_chan
`default_nettype wire

// *** tmc_top.sv ***
// Purpose: Timer modulo limit, shared counter and two channel flag registers
// Assumes: TICK is a prescaled one-cycle enable on CLOCK; pins are asynchronous
// Notes:   Registers sit on AXI4-Lite; one write and one read in flight
//
// Added by the designer: the AXI4-Lite interface to the registers.
`default_nettype none
module tmc_top (
  input  wire logic                        CLOCK,           // 10 MHz clock
  input  wire logic                        RST_N,           // Async reset
  input  wire logic                        TICK,            // Timer clock enable
  input  wire logic                        CENTER_ALIGN,    // center_align_select
  input  wire logic [15:0]                 CH0_VALUE,       // Channel 0 value
  input  wire logic [15:0]                 CH1_VALUE,       // Channel 1 value
  input  wire logic [1:0]                  CH_PIN_IN,       // Channel pin levels
  output logic [1:0]                       CH_PIN_OUT,      // Channel pin drive
  output logic [1:0]                       CH_PIN_OE,       // Channel pin enable
  output logic [1:0]                       CH_IRQ,          // Channel requests
  output logic [15:0]                      COUNT,           // Counter value
  output logic                             OVERFLOW_SET,    // Overflow event
  output logic                             OVERFLOW_INHIBIT,// Half-written limit
  input  wire logic                        S_AXI_AWVALID,   // Write address valid
  output logic                             S_AXI_AWREADY,   // Write address ready
  input  wire logic [tmc_pkg::ADDR_W-1:0]  S_AXI_AWADDR,    // Write address
  input  wire logic                        S_AXI_WVALID,    // Write data valid
  output logic                             S_AXI_WREADY,    // Write data ready
  input  wire logic [tmc_pkg::DATA_W-1:0]  S_AXI_WDATA,     // Write data
  input  wire logic [3:0]                  S_AXI_WSTRB,     // Byte enables
  output logic                             S_AXI_BVALID,    // Response valid
  input  wire logic                        S_AXI_BREADY,    // Response ready
  output logic [1:0]                       S_AXI_BRESP,     // Write response
  input  wire logic                        S_AXI_ARVALID,   // Read address valid
  output logic                             S_AXI_ARREADY,   // Read address ready
  input  wire logic [tmc_pkg::ADDR_W-1:0]  S_AXI_ARADDR,    // Read address
  output logic                             S_AXI_RVALID,    // Read data valid
  input  wire logic                        S_AXI_RREADY,    // Read data ready
  output logic [tmc_pkg::DATA_W-1:0]       S_AXI_RDATA,     // Read data
  output logic [1:0]                       S_AXI_RRESP      // Read response
);
  // Register select from a byte address; used by both bus paths
  function automatic logic [3:0] sel(input logic [tmc_pkg::ADDR_W-1:0] a);
    logic [3:0] s;
    s = 4'h0;
    if (a[1:0] == 2'b00) begin
      s[0] = a[7:2] == tmc_pkg::IDX_LIMIT_HI[5:0];
      s[1] = a[7:2] == tmc_pkg::IDX_LIMIT_LO[5:0];
      s[2] = a[7:2] == tmc_pkg::IDX_CH0_SC[5:0];
      s[3] = a[7:2] == tmc_pkg::IDX_CH1_SC[5:0];
    end
    return s;
  endfunction : sel

  logic [1:0]                      pin_meta;   // Synchroniser stage one
  logic [1:0]                      pin_sync;   // Synchroniser stage two
  logic [15:0]                     limit;      // Active counter_limit
  logic [7:0]                      buf_hi;     // Pending high byte
  logic [7:0]                      buf_lo;     // Pending low byte
  logic                            got_hi;     // High byte written
  logic                            got_lo;     // Low byte written
  logic [15:0]                     top;        // Effective terminal count
  logic                            at_top;     // Counter at terminal count
  tmc_pkg::tmc_dir_t               dir;        // Count direction
  logic                            aw_got;     // Write address held
  logic                            w_got;      // Write data held
  logic [tmc_pkg::ADDR_W-1:0]      aw_addr;    // Held write address
  logic [7:0]                      w_byte;     // Held low data byte
  logic                            w_lane;     // Low byte lane enabled
  logic                            do_wr;      // Write performed this cycle
  logic [3:0]                      wr_sel;     // Write register select
  logic [3:0]                      rd_sel;     // Read register select
  logic                            rd_go;      // Read accepted
  logic [7:0]                      rd_byte;    // Read mux result
  logic [7:0]                      sc_byte [tmc_pkg::NUM_CH]; // Channel readback
  logic [15:0]                     ch_value[tmc_pkg::NUM_CH]; // Channel values
  tmc_pkg::tmc_chan_bus_t          ch_bus  [tmc_pkg::NUM_CH]; // Channel access

  // Two-stage synchronisers on the channel pins
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pin_meta <= 2'b00;
      pin_sync <= 2'b00;
    end else begin
      pin_meta <= CH_PIN_IN;
      pin_sync <= pin_meta;
    end
  end

  // Write channels: take address and data in either order
  assign S_AXI_AWREADY = !aw_got && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_got && !S_AXI_BVALID;
  assign do_wr         = aw_got && w_got;
  assign wr_sel        = do_wr && w_lane ? sel(aw_addr) : 4'h0;

  // Hold write address
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      aw_got  <= 1'b0;
      aw_addr <= '0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_got  <= 1'b1;
      aw_addr <= S_AXI_AWADDR;
    end else if (do_wr) begin
      aw_got  <= 1'b0;
    end
  end

  // Hold write data; only the low lane carries register bits
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      w_got  <= 1'b0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_got  <= 1'b1;
      w_byte <= S_AXI_WDATA[7:0];
      w_lane <= S_AXI_WSTRB[0];
    end else if (do_wr) begin
      w_got  <= 1'b0;
    end
  end

  // Write response follows the performed write
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= tmc_pkg::RESP_OKAY;
    end else if (do_wr) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= sel(aw_addr) != 4'h0 ? tmc_pkg::RESP_OKAY : tmc_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Read path: one-cycle answer, held until taken
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign rd_go         = S_AXI_ARVALID && S_AXI_ARREADY;
  assign rd_sel        = sel(S_AXI_ARADDR);

  // Read mux of the four byte registers
  always_comb begin
    case (rd_sel)
      4'h1:    rd_byte = limit[15:8];
      4'h2:    rd_byte = limit[7:0];
      4'h4:    rd_byte = sc_byte[0];
      4'h8:    rd_byte = sc_byte[1];
      default: rd_byte = 8'h00;
    endcase
  end

  // Read data register; upper bits read zero
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= '0;
      S_AXI_RRESP  <= tmc_pkg::RESP_OKAY;
    end else if (rd_go) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= {24'h000000, rd_byte};
      S_AXI_RRESP  <= rd_sel != 4'h0 ? tmc_pkg::RESP_OKAY : tmc_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // Byte pairing for the modulo value; the pair commits together so the
  // comparison never sees a half-updated limit
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      limit  <= tmc_pkg::LIMIT_RST;
      buf_hi <= 8'h00;
      buf_lo <= 8'h00;
      got_hi <= 1'b0;
      got_lo <= 1'b0;
    end else if ((wr_sel[0] && got_lo) || (wr_sel[1] && got_hi)) begin
      limit  <= wr_sel[0] ? {w_byte, buf_lo} : {buf_hi, w_byte};
      got_hi <= 1'b0;
      got_lo <= 1'b0;
    end else if (wr_sel[0]) begin
      buf_hi <= w_byte;
      got_hi <= 1'b1;
    end else if (wr_sel[1]) begin
      buf_lo <= w_byte;
      got_lo <= 1'b1;
    end
  end

  assign OVERFLOW_INHIBIT = got_hi || got_lo;
  assign top    = limit == 16'h0000 ? tmc_pkg::FULL_TOP : limit;
  assign at_top = COUNT == top;

  // Shared counter, advanced on each timer tick
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      COUNT <= 16'h0000;
      dir   <= tmc_pkg::TMC_UP;
    end else if (TICK) begin
      if (!CENTER_ALIGN) begin
        dir   <= tmc_pkg::TMC_UP;
        COUNT <= at_top ? 16'h0000 : COUNT + 16'h0001;
      end else begin
        case (dir)
          tmc_pkg::TMC_UP: begin
            if (at_top) begin
              dir   <= tmc_pkg::TMC_DOWN;
              COUNT <= COUNT - 16'h0001;
            end else begin
              COUNT <= COUNT + 16'h0001;
            end
          end
          tmc_pkg::TMC_DOWN: begin
            if (COUNT == 16'h0000) begin
              dir   <= tmc_pkg::TMC_UP;
              COUNT <= 16'h0001;
            end else begin
              COUNT <= COUNT - 16'h0001;
            end
          end
          default: dir <= tmc_pkg::TMC_UP;
        endcase
      end
    end
  end

  // Overflow event pulse to the main status flag
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      OVERFLOW_SET <= 1'b0;
    end else begin
      OVERFLOW_SET <= TICK && at_top && (!CENTER_ALIGN || dir == tmc_pkg::TMC_UP)
                      && !OVERFLOW_INHIBIT;
    end
  end

  assign ch_value[0] = CH0_VALUE;
  assign ch_value[1] = CH1_VALUE;

  // One channel instance per pin
  genvar g;
  generate
    for (g = 0; g < tmc_pkg::NUM_CH; g++) begin : gen_ch
      assign ch_bus[g].rd    = rd_go && rd_sel[2+g];
      assign ch_bus[g].wr    = wr_sel[2+g];
      assign ch_bus[g].wdata = w_byte;
      tmc_chan u_chan (
        .clk     (CLOCK),
        .rst_n   (RST_N),
        .tick    (TICK),
        .center  (CENTER_ALIGN),
        .count   (COUNT),
        .value   (ch_value[g]),
        .pin_in  (pin_sync[g]),
        .bus     (ch_bus[g]),
        .sc_byte (sc_byte[g]),
        .irq     (CH_IRQ[g]),
        .pin_out (CH_PIN_OUT[g]),
        .pin_oe  (CH_PIN_OE[g])
      );
    end
  endgenerate
endmodule : tmc_top
`default_nettype wire

// *** tmc_chk.sv ***
// Purpose: Port-level checks for the timer modulo and channel block
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound to tmc_top after the module
`default_nettype none
module tmc_chk (
  input wire logic        CLOCK,            // Clock
  input wire logic        RST_N,            // Reset, active low
  input wire logic        TICK,             // Timer enable
  input wire logic        CENTER_ALIGN,     // Up/down select
  input wire logic [1:0]  CH_IRQ,           // Channel requests
  input wire logic [15:0] COUNT,            // Counter
  input wire logic        OVERFLOW_SET,     // Overflow pulse
  input wire logic        OVERFLOW_INHIBIT, // Half-written limit
  input wire logic        S_AXI_AWVALID,    // Write address valid
  input wire logic        S_AXI_AWREADY,    // Write address ready
  input wire logic        S_AXI_WVALID,     // Write data valid
  input wire logic        S_AXI_WREADY,     // Write data ready
  input wire logic        S_AXI_BVALID,     // Write response valid
  input wire logic        S_AXI_ARVALID,    // Read address valid
  input wire logic        S_AXI_ARREADY,    // Read address ready
  input wire logic        S_AXI_RVALID      // Read data valid
);
  // One domain, so reset silences every check at once
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);
  a_up_step: assert property (
    TICK && !CENTER_ALIGN |=> COUNT == $past(COUNT) + 16'h0001 || COUNT == 16'h0000)
    else $error("counter did not step or wrap");
  a_idle_hold: assert property (!TICK |=> $stable(COUNT))
    else $error("counter moved without a tick");
  a_center_turn: assert property (
    TICK && CENTER_ALIGN |=> COUNT == $past(COUNT) + 16'h0001
    || COUNT == $past(COUNT) - 16'h0001)
    else $error("center count jumped");
  a_ovf_pulse: assert property (OVERFLOW_SET |=> !OVERFLOW_SET)
    else $error("overflow pulse too long");
  a_ovf_zero: assert property (
    OVERFLOW_SET && !CENTER_ALIGN && !$past(CENTER_ALIGN) |-> $past(TICK) && COUNT == 16'h0000)
    else $error("overflow without wrap");
  a_ovf_quiet: assert property (
    OVERFLOW_INHIBIT && $past(OVERFLOW_INHIBIT) |-> !OVERFLOW_SET)
    else $error("overflow while limit half written");
  a_wr_answer: assert property (
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
    else $error("write response late");
  a_rd_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read data late");
  a_irq_reset: assert property ($rose(RST_N) |-> CH_IRQ == 2'h0)
    else $error("request right after reset");
  // Main scenarios reached
  c_ovf: cover property (OVERFLOW_SET);
  c_irq: cover property (CH_IRQ != 2'h0);
  c_center: cover property (CENTER_ALIGN && TICK);
endmodule : tmc_chk
bind tmc_top tmc_chk i_tmc_chk (
  .CLOCK, .RST_N, .TICK, .CENTER_ALIGN, .CH_IRQ, .COUNT, .OVERFLOW_SET, .OVERFLOW_INHIBIT,
  .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID,
  .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID);
`default_nettype wire

// *** tb_timer_modulo_channel_flags.sv ***
// Purpose: Self-checking bench for the timer modulo and channel block
// Assumes: Registers over AXI4-Lite; ticks every other clock when enabled
// Notes:   Small limits keep every scenario to a few hundred cycles
`default_nettype none
module tb_timer_modulo_channel_flags;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] A_HI = tmc_pkg::IDX_LIMIT_HI << 2; // Limit high byte
  localparam logic [7:0] A_LO = tmc_pkg::IDX_LIMIT_LO << 2; // Limit low byte
  localparam logic [7:0] A_C0 = tmc_pkg::IDX_CH0_SC << 2;   // Channel 0 byte
  localparam logic [7:0] A_C1 = tmc_pkg::IDX_CH1_SC << 2;   // Channel 1 byte
  localparam logic [1:0] OK   = tmc_pkg::RESP_OKAY;         // Mapped
  localparam logic [1:0] ERR  = tmc_pkg::RESP_SLVERR;       // Unmapped
  logic        CLOCK, RST_N, TICK, CENTER_ALIGN;            // Clock, reset, mode
  logic [15:0] CH0_VALUE, CH1_VALUE, COUNT;                 // Values, counter
  logic [1:0]  CH_PIN_IN, CH_PIN_OUT, CH_PIN_OE, CH_IRQ;    // Pins, requests
  logic        OVERFLOW_SET, OVERFLOW_INHIBIT;              // Overflow signals
  logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
  logic        S_AXI_RVALID, S_AXI_RREADY;                  // Read handshake
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;                  // Addresses
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;                    // Data
  logic [3:0]  S_AXI_WSTRB;                                 // Byte enables
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;                    // Responses
  logic        tick_en;                                     // Lets ticks run
  int          n_errors, samples_checked;                   // Report counters
  logic [7:0]  cap_sc [4] = '{8'h04, 8'h04, 8'h08, 8'h0C};  // Capture codes
  logic [7:0]  cap_ex [4] = '{8'h84, 8'h04, 8'h88, 8'h8C};  // Expected bytes
  logic [3:0]  cap_pre = 4'h6;                              // Pin level before
  tmc_top i_tmc_top (
    .CLOCK, .RST_N, .TICK, .CENTER_ALIGN, .CH0_VALUE, .CH1_VALUE, .CH_PIN_IN, .CH_PIN_OUT,
    .CH_PIN_OE, .CH_IRQ, .COUNT, .OVERFLOW_SET, .OVERFLOW_INHIBIT, .S_AXI_AWVALID,
    .S_AXI_AWREADY, .S_AXI_AWADDR, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
    .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_BRESP, .S_AXI_ARVALID, .S_AXI_ARREADY,
    .S_AXI_ARADDR, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA, .S_AXI_RRESP);
  // 100 ns clock
  initial begin
    CLOCK = 1'b0;
    forever #50 CLOCK = ~CLOCK;
  end
  // Tick every other clock, so each count value lasts two cycles
  always @(posedge CLOCK) begin
    TICK <= tick_en & ~TICK;
  end
  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // A bounded wait that ran out ends the run
  task automatic tmo(input logic ok);
    if (!ok) begin
      n_errors++;
      $display("wrong value wait expected answer seen timeout");
      close_out();
    end
  endtask : tmo
  // One register access; entered just after a rising edge, leaves on one
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] er, input logic [7:0] ed);
    logic ta, tw, done;
    logic [1:0] rsp;
    logic [31:0] got;
    int n;
    done = 1'b0;
    n = 0;
    S_AXI_AWADDR <= a;
    S_AXI_ARADDR <= a;
    S_AXI_WDATA <= {24'h000000, d};
    S_AXI_AWVALID <= wr;
    S_AXI_WVALID <= wr;
    S_AXI_BREADY <= wr;
    S_AXI_ARVALID <= ~wr;
    S_AXI_RREADY <= ~wr;
    while (!done && n < 60) begin
      @(negedge CLOCK);
      ta = wr ? S_AXI_AWVALID && S_AXI_AWREADY : S_AXI_ARVALID && S_AXI_ARREADY;
      tw = S_AXI_WVALID && S_AXI_WREADY;
      done = wr ? S_AXI_BVALID : S_AXI_RVALID;
      rsp = wr ? S_AXI_BRESP : S_AXI_RRESP;
      got = S_AXI_RDATA;
      @(posedge CLOCK);
      n++;
      // Each channel drops only after its own handshake edge
      if (ta) begin
        S_AXI_AWVALID <= 1'b0;
        S_AXI_ARVALID <= 1'b0;
      end
      if (tw) S_AXI_WVALID <= 1'b0;
    end
    tmo(done);
    chk("response", 32'(er), 32'(rsp));
    if (!wr) chk("read data", 32'(ed), got);
  endtask : bus
  task automatic do_reset();
    RST_N <= 1'b0;
    tick_en <= 1'b0;
    CENTER_ALIGN <= 1'b0;
    repeat (6) @(posedge CLOCK);
    RST_N <= 1'b1;
    @(posedge CLOCK);
  endtask : do_reset
  // Wait at falling edges until COUNT equals v (eq) or leaves it
  task automatic wait_count(input logic [15:0] v, input logic eq);
    int n;
    n = 0;
    do begin
      @(negedge CLOCK);
      n++;
    end while (((COUNT == v) != eq) && n < 60);
    tmo(n < 60);
  endtask : wait_count
  task automatic s_reset_vals();
    bus(1'b0, A_HI, 8'h00, OK, 8'h00);
    bus(1'b0, A_LO, 8'h00, OK, 8'h00);
    bus(1'b0, A_C0, 8'h00, OK, 8'h00);
    bus(1'b0, A_C1, 8'h00, OK, 8'h00);
    bus(1'b0, 8'h00, 8'h00, ERR, 8'h00);
    bus(1'b1, 8'h04, 8'hFF, ERR, 8'h00);
    chk("irq", 32'h00000000, 32'(CH_IRQ));
    chk("pin enable", 32'h00000000, 32'(CH_PIN_OE));
  endtask : s_reset_vals
  task automatic s_limit();
    int n;
    logic [15:0] mx;
    bus(1'b1, A_LO, 8'h05, OK, 8'h00);
    bus(1'b0, A_LO, 8'h00, OK, 8'h00);
    chk("inhibit", 32'h00000001, 32'(OVERFLOW_INHIBIT));
    bus(1'b1, A_HI, 8'h00, OK, 8'h00);
    bus(1'b0, A_LO, 8'h00, OK, 8'h05);
    chk("inhibit", 32'h00000000, 32'(OVERFLOW_INHIBIT));
    tick_en <= 1'b1;
    n = 0;
    do begin
      @(negedge CLOCK);
      n++;
    end while (OVERFLOW_SET !== 1'b1 && n < 60);
    tmo(n < 60);
    chk("count after wrap", 32'h00000000, 32'(COUNT));
    mx = 16'h0000;
    repeat (30) begin
      @(negedge CLOCK);
      if (COUNT > mx) mx = COUNT;
    end
    chk("count top", 32'h00000005, 32'(mx));
    @(posedge CLOCK);
    bus(1'b1, A_HI, 8'h00, OK, 8'h00);
    n = 0;
    repeat (30) begin
      @(negedge CLOCK);
      if (OVERFLOW_SET !== 1'b0) n++;
    end
    chk("pulses while inhibited", 32'h00000000, 32'(n));
    @(posedge CLOCK);
    bus(1'b1, A_LO, 8'h05, OK, 8'h00);
  endtask : s_limit
  // Compare or PWM channel: flag, enable, clear sequence
  task automatic s_chan(input int ch, input logic [7:0] a, input logic [7:0] sc);
    tick_en <= 1'b1;
    bus(1'b1, a, sc | 8'h03, OK, 8'h00);
    chk("pin enable", 32'h00000001, 32'(CH_PIN_OE[ch]));
    repeat (14) @(posedge CLOCK);
    bus(1'b0, a, 8'h00, OK, 8'h80 | sc);
    bus(1'b1, a, 8'hC0 | sc, OK, 8'h00);
    bus(1'b0, a, 8'h00, OK, 8'hC0 | sc);
    chk("irq", 32'h00000001, 32'(CH_IRQ[ch]));
    // event between read and write keeps flag
    repeat (14) @(posedge CLOCK);
    bus(1'b1, a, 8'h40 | sc, OK, 8'h00);
    bus(1'b0, a, 8'h00, OK, 8'hC0 | sc);
    tick_en <= 1'b0;
    repeat (4) @(posedge CLOCK);
    bus(1'b0, a, 8'h00, OK, 8'hC0 | sc);
    bus(1'b1, a, 8'h40 | sc, OK, 8'h00);
    bus(1'b0, a, 8'h00, OK, 8'h40 | sc);
    chk("irq", 32'h00000000, 32'(CH_IRQ[ch]));
  endtask : s_chan
  // Capture edges on channel 1: rising, wrong edge, falling, both
  task automatic s_capture();
    for (int i = 0; i < 4; i++) begin
      do_reset();
      CH_PIN_IN <= {cap_pre[i], 1'b0};
      repeat (6) @(posedge CLOCK);
      bus(1'b1, A_C1, cap_sc[i], OK, 8'h00);
      CH_PIN_IN <= {~cap_pre[i], 1'b0};
      repeat (6) @(posedge CLOCK);
      bus(1'b0, A_C1, 8'h00, OK, cap_ex[i]);
    end
  endtask : s_capture
  task automatic s_center();
    do_reset();
    bus(1'b1, A_LO, 8'h04, OK, 8'h00);
    bus(1'b1, A_HI, 8'h00, OK, 8'h00);
    CENTER_ALIGN <= 1'b1;
    CH0_VALUE <= 16'h0002;
    bus(1'b1, A_C0, 8'h08, OK, 8'h00);
    tick_en <= 1'b1;
    wait_count(16'h0001, 1'b1);
    chk("pwm pin below value", 32'h00000001, 32'(CH_PIN_OUT[0]));
    wait_count(16'h0004, 1'b1);
    chk("pwm pin above value", 32'h00000000, 32'(CH_PIN_OUT[0]));
    wait_count(16'h0004, 1'b0);
    chk("count after top", 32'h00000003, 32'(COUNT));
    @(posedge CLOCK);
    bus(1'b0, A_C0, 8'h00, OK, 8'h88);
  endtask : s_center
  initial begin
    TICK = 1'b0;
    CH0_VALUE = 16'h0003;
    CH1_VALUE = 16'h0003;
    CH_PIN_IN = 2'h0;
    S_AXI_AWVALID = 1'b0;
    S_AXI_WVALID = 1'b0;
    S_AXI_BREADY = 1'b0;
    S_AXI_ARVALID = 1'b0;
    S_AXI_RREADY = 1'b0;
    S_AXI_WSTRB = 4'hF;
    n_errors = 0;
    samples_checked = 0;
    do_reset();
    s_reset_vals();
    s_limit();
    s_chan(0, A_C0, 8'h14);
    s_chan(1, A_C1, 8'h28);
    s_capture();
    s_center();
    close_out();
  end
endmodule : tb_timer_modulo_channel_flags
`default_nettype wire
